// ---- logic/scg_defines.svh ----
// Register offsets, field positions, reset values and timing figures
// for the system clock generator. Included by the package and the core.
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// Register byte offsets
`define SCG_CTRL_OFS 8'h00
`define SCG_PRESC_OFS 8'h04
`define SCG_PLLDIV_OFS 8'h08
`define SCG_STATUS_OFS 8'h0c

// Source select codes
`define SCG_SEL_WAKEUP 2'h0
`define SCG_SEL_OSC_PLL 2'h2
`define SCG_SEL_DIRECT 2'h3

// Field widths
`define SCG_K1_W 10
`define SCG_P_W 4
`define SCG_N_W 7
`define SCG_K2_W 7
`define SCG_VCO_W 16

// Control register field positions
`define SCG_CTRL_SEL_LSB 0
`define SCG_CTRL_BYP_BIT 2
`define SCG_CTRL_REF_BIT 3
`define SCG_CTRL_BAND_LSB 4

// PLL divider register field positions
`define SCG_PLL_P_LSB 0
`define SCG_PLL_N_LSB 8
`define SCG_PLL_K2_LSB 16

// Reset values
`define SCG_SEL_RESET 2'h0
`define SCG_BYP_RESET 1'h1
`define SCG_BAND_RESET 2'h0

// VCO half period limits in system clock cycles, per band
`define SCG_VCO_MIN_B0 16'h0004
`define SCG_VCO_MAX_B0 16'h0100
`define SCG_VCO_MIN_B1 16'h0002
`define SCG_VCO_MAX_B1 16'h0080
`define SCG_VCO_HALF_RESET 16'h0010

`endif

// ---- logic/scg_pkg.sv ----
// Types of the system clock generator: switch states and core state.
// Assumes scg_defines.svh is on the include path.
`include "scg_defines.svh"

package scg_pkg;

    // Source switch states, Gray coded along run, drain, arm
    typedef enum logic [1:0] {
        SCG_RUN = 2'h0,
        SCG_DRAIN = 2'h1,
        SCG_ARM = 2'h3
    } scg_sw_type;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scg_bus_type;

    // Whole state of the core
    typedef struct packed {
        logic [31:0] rd_data;
        logic [1:0] src_sel;
        logic byp;
        logic ref_sel;
        logic [1:0] band;
        logic [`SCG_K1_W-1:0] k1;
        logic [`SCG_P_W-1:0] in_div;
        logic [`SCG_N_W-1:0] fb_mul;
        logic [`SCG_K2_W-1:0] k2;
        logic [1:0] act_sel;
        logic act_byp;
        logic act_ref;
        scg_sw_type sw;
        logic osc_prev;
        logic [`SCG_K1_W-1:0] k1_cnt;
        logic [`SCG_P_W-1:0] p_cnt;
        logic [`SCG_N_W:0] vcnt;
        logic [`SCG_VCO_W-1:0] vco_half;
        logic [`SCG_VCO_W-1:0] vco_tmr;
        logic vco_lvl;
        logic [`SCG_K2_W-1:0] k2_cnt;
        logic locked;
        logic clk_out;
    } scg_state_type;

endpackage : scg_pkg

// ---- logic/scg_core.sv ----
// System clock generator: selects direct, prescaled, PLL or wakeup
// clock and switches between them without runt phases.
// Assumes all source levels are sampled on sys_clk, which is fast
// enough to see every phase of each source.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_core
    import scg_pkg::*;
#(
    parameter logic [`SCG_VCO_W-1:0] VCO_HALF_INIT = `SCG_VCO_HALF_RESET
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire scg_bus_type bus,
    output logic [31:0] rd_data,
    // Clock source levels
    input wire logic direct_clock_input,
    input wire logic crystal_input,
    input wire logic internal_osc_input,
    input wire logic wakeup_oscillator_clock,
    // Generated clock and status
    output logic system_clock,
    output logic pll_locked,
    output logic switch_busy
);

    // Refuse a zero VCO start value
    if (VCO_HALF_INIT == '0) begin : g_chk
        $error("VCO_HALF_INIT must be nonzero");
    end

    scg_state_type q; // Registered state
    scg_state_type d; // Next state
    logic osc_lvl; // Selected oscillator level
    logic osc_rise; // Rising edge of selected oscillator
    logic pll_on; // PLL enabled by the active or the requested setting
    logic presc_lvl; // Prescaler output level
    logic pll_lvl; // PLL output level
    logic act_lvl; // Level of the active source
    logic new_lvl; // Level of the newly requested source
    logic vco_rise; // VCO rising edge this cycle
    logic pfd; // Divided reference edge this cycle
    logic [`SCG_VCO_W-1:0] vmin; // Band lower limit
    logic [`SCG_VCO_W-1:0] vmax; // Band upper limit
    logic [9:0] k2_nx; // Next output divider count, widened
    logic [9:0] p_nx; // Next input divider count, widened

    // Next value of a wrapping divider counter
    function automatic logic [9:0] div_next(input logic [9:0] cnt,
                                            input logic [9:0] fld);
        div_next = (cnt >= fld) ? 10'h000 : cnt + 10'h001;
    endfunction : div_next

    // Divider output level: source itself for divide by one
    function automatic logic div_lvl(input logic [9:0] cnt,
                                     input logic [9:0] fld,
                                     input logic src);
        logic [10:0] half;
        half = ({1'b0, fld} + 11'h001) >> 1;
        div_lvl = (fld == 10'h000) ? src : ({1'b0, cnt} < half);
    endfunction : div_lvl

    // Output level of a source for a given configuration
    function automatic logic src_lvl(input logic [1:0] sel,
                                     input logic byp,
                                     input logic dir,
                                     input logic wu,
                                     input logic pre,
                                     input logic pll);
        case (sel)
            `SCG_SEL_DIRECT: src_lvl = dir;
            `SCG_SEL_OSC_PLL: src_lvl = byp ? pre : pll;
            `SCG_SEL_WAKEUP: src_lvl = wu;
            default: src_lvl = 1'b0;
        endcase
    endfunction : src_lvl

    // Source levels, edges and band limits
    always_comb begin
        osc_lvl = q.act_ref ? internal_osc_input : crystal_input;
        osc_rise = osc_lvl & ~q.osc_prev;
        // Also run for a requested PLL so a switch to it can complete
        pll_on = ((q.act_sel == `SCG_SEL_OSC_PLL) & ~q.act_byp)
                 | ((q.src_sel == `SCG_SEL_OSC_PLL) & ~q.byp);
        presc_lvl = div_lvl(q.k1_cnt, q.k1, osc_lvl);
        pll_lvl = div_lvl({3'h0, q.k2_cnt}, {3'h0, q.k2}, q.vco_lvl);
        act_lvl = src_lvl(q.act_sel, q.act_byp, direct_clock_input,
                          wakeup_oscillator_clock, presc_lvl, pll_lvl);
        new_lvl = src_lvl(q.src_sel, q.byp, direct_clock_input,
                          wakeup_oscillator_clock, presc_lvl, pll_lvl);
        vco_rise = pll_on & (q.vco_tmr == '0) & ~q.vco_lvl;
        pfd = pll_on & osc_rise & (q.p_cnt >= q.in_div);
        k2_nx = div_next({3'h0, q.k2_cnt}, {3'h0, q.k2});
        p_nx = div_next({6'h0, q.p_cnt}, {6'h0, q.in_div});
        vmin = q.band[0] ? `SCG_VCO_MIN_B1 : `SCG_VCO_MIN_B0;
        vmax = q.band[0] ? `SCG_VCO_MAX_B1 : `SCG_VCO_MAX_B0;
    end

    // Next state: registers, dividers, PLL loop and source switch
    always_comb begin
        d = q;
        d.rd_data = 32'h0000_0000;
        d.osc_prev = osc_lvl;
        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                `SCG_CTRL_OFS: begin
                    d.src_sel = bus.wdata[`SCG_CTRL_SEL_LSB +: 2];
                    d.byp = bus.wdata[`SCG_CTRL_BYP_BIT];
                    d.ref_sel = bus.wdata[`SCG_CTRL_REF_BIT];
                    // Reserved band codes keep the old band
                    if (!bus.wdata[`SCG_CTRL_BAND_LSB + 1]) begin
                        d.band = bus.wdata[`SCG_CTRL_BAND_LSB +: 2];
                    end
                end
                `SCG_PRESC_OFS: begin
                    d.k1 = bus.wdata[`SCG_K1_W-1:0];
                end
                `SCG_PLLDIV_OFS: begin
                    d.in_div = bus.wdata[`SCG_PLL_P_LSB +: `SCG_P_W];
                    d.fb_mul = bus.wdata[`SCG_PLL_N_LSB +: `SCG_N_W];
                    d.k2 = bus.wdata[`SCG_PLL_K2_LSB +: `SCG_K2_W];
                end
                default: begin
                end
            endcase
        end
        // Register reads, data valid next cycle only
        if (bus.rd) begin
            case (bus.addr)
                `SCG_CTRL_OFS: d.rd_data = {26'h0, q.band, q.ref_sel,
                                            q.byp, q.src_sel};
                `SCG_PRESC_OFS: d.rd_data = {22'h0, q.k1};
                `SCG_PLLDIV_OFS: d.rd_data = {9'h0, q.k2, 1'b0, q.fb_mul,
                                              4'h0, q.in_div};
                `SCG_STATUS_OFS: d.rd_data = {25'h0, q.clk_out,
                                              q.locked, q.sw != SCG_RUN,
                                              q.act_ref, q.act_byp,
                                              q.act_sel};
                default: d.rd_data = 32'h0000_0000;
            endcase
        end
        // Prescaler counts oscillator rising edges
        if (osc_rise) begin
            d.k1_cnt = div_next(q.k1_cnt, q.k1);
        end
        // VCO: half period timer toggles the VCO level
        if (pll_on) begin
            if (q.vco_tmr == '0) begin
                d.vco_tmr = q.vco_half;
                d.vco_lvl = ~q.vco_lvl;
            end else begin
                d.vco_tmr = q.vco_tmr - 1'b1;
            end
            if (vco_rise) begin
                d.k2_cnt = k2_nx[`SCG_K2_W-1:0];
                if (q.vcnt != '1) begin
                    d.vcnt = q.vcnt + 1'b1;
                end
            end
            if (osc_rise) begin
                d.p_cnt = p_nx[`SCG_P_W-1:0];
            end
            // Compare VCO cycles per divided reference with N
            if (pfd) begin
                d.vcnt = '0;
                d.locked = (q.vcnt == {1'b0, q.fb_mul} + 1'b1);
                // One cycle step per comparison keeps changes smooth
                if (q.vcnt < {1'b0, q.fb_mul} + 1'b1) begin
                    if (q.vco_half > vmin) begin
                        d.vco_half = q.vco_half - 1'b1;
                    end
                end else if (q.vcnt > {1'b0, q.fb_mul} + 1'b1) begin
                    if (q.vco_half < vmax) begin
                        d.vco_half = q.vco_half + 1'b1;
                    end
                end
            end
            // Keep the loop inside the selected band
            if (q.vco_half < vmin) begin
                d.vco_half = vmin;
            end else if (q.vco_half > vmax) begin
                d.vco_half = vmax;
            end
        end else begin
            d.locked = 1'b0;
            d.vcnt = '0;
            d.p_cnt = '0;
        end
        // Glitch free source switch
        case (q.sw)
            SCG_RUN: begin
                d.clk_out = act_lvl;
                if ({q.src_sel, q.byp, q.ref_sel} !=
                    {q.act_sel, q.act_byp, q.act_ref}) begin
                    d.sw = SCG_DRAIN;
                end
            end
            SCG_DRAIN: begin
                // Finish the running high phase of the old source
                d.clk_out = act_lvl & q.clk_out;
                if (!act_lvl) begin
                    d.sw = SCG_ARM;
                end
            end
            SCG_ARM: begin
                // Hold low until the new source is low as well
                d.clk_out = 1'b0;
                if (!new_lvl) begin
                    d.act_sel = q.src_sel;
                    d.act_byp = q.byp;
                    d.act_ref = q.ref_sel;
                    d.sw = SCG_RUN;
                end
            end
            default: begin
                d.clk_out = 1'b0;
                d.sw = SCG_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.src_sel <= `SCG_SEL_RESET;
            q.byp <= `SCG_BYP_RESET;
            q.band <= `SCG_BAND_RESET;
            q.act_sel <= `SCG_SEL_RESET;
            q.act_byp <= `SCG_BYP_RESET;
            q.sw <= SCG_RUN;
            q.vco_half <= VCO_HALF_INIT;
        end else begin
            q <= d;
        end
    end

    // Outputs from flip-flops, switch_busy decoded from the switch state
    assign rd_data = q.rd_data;
    assign system_clock = q.clk_out;
    assign pll_locked = q.locked;
    assign switch_busy = q.sw != SCG_RUN;

    // Direct drive follows the input one cycle later
    AST_DIRECT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (q.sw == SCG_RUN && d.sw == SCG_RUN
         && q.act_sel == `SCG_SEL_DIRECT)
        |=> system_clock == $past(direct_clock_input))
        else $error("direct drive output differs from input");

    // Wakeup mode follows the wakeup oscillator
    AST_WAKEUP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (q.sw == SCG_RUN && d.sw == SCG_RUN
         && q.act_sel == `SCG_SEL_WAKEUP)
        |=> system_clock == $past(wakeup_oscillator_clock))
        else $error("wakeup output differs from oscillator");

    // Prescaler counter steps by one on each oscillator edge below the field
    AST_PRESC_STEP: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (osc_rise && q.k1_cnt < q.k1 && !bus.wr)
        |=> q.k1_cnt == $past(q.k1_cnt) + 1'b1)
        else $error("prescaler counter did not advance");

    // Divide by field plus one: a full K1 span of edges wraps to zero
    AST_PRESC_WRAP: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        (osc_rise && q.k1_cnt == q.k1) |=> q.k1_cnt == '0)
        else $error("prescaler did not wrap at its limit");

    // Reserved band codes never take effect
    AST_BAND: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus.wr && bus.addr == `SCG_CTRL_OFS
         && bus.wdata[`SCG_CTRL_BAND_LSB + 1])
        |=> q.band == $past(q.band))
        else $error("reserved band code accepted");

    // VCO period moves by at most one step per cycle unless a band change clamps it
    AST_SMOOTH: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (pll_on && $past(pll_on) && $stable(q.band))
        |-> (q.vco_half == $past(q.vco_half)
             || q.vco_half == $past(q.vco_half) + 1'b1
             || q.vco_half == $past(q.vco_half) - 1'b1))
        else $error("VCO period jumped");

    // PLL off keeps the VCO still and unlocked
    AST_PLL_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !pll_on |=> ($stable(q.vco_lvl) && !pll_locked))
        else $error("VCO ran while PLL disabled");

    // Output divider stays within K2 states
    AST_K2: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (vco_rise && q.k2_cnt >= q.k2) |=> q.k2_cnt == '0)
        else $error("output divider overran K2");

    // Arming holds the output low for the whole wait
    AST_ARM_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (q.sw == SCG_ARM) |=> !system_clock)
        else $error("output high while arming new source");

    // Drain never raises the output
    AST_DRAIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (q.sw == SCG_DRAIN && !system_clock) |=> !system_clock)
        else $error("output rose while draining old source");

endmodule : scg_core

// ---- verif/scg_src_model.sv ----
// Free-running clock sources that feed the system clock generator.
// Assumes the generator samples every source level on sys_clk.
`timescale 1ns/1ns

module scg_src_model #(
    parameter int XTAL_HALF = 16,
    parameter int INT_HALF = 3,
    parameter int WU_HALF = 6,
    parameter int DIR_HI = 3,
    parameter int DIR_LO = 5
) (
    // Sampling clock
    input wire logic sys_clk,
    // Source levels
    output logic direct_clock_input,
    output logic crystal_input,
    output logic internal_osc_input,
    output logic wakeup_oscillator_clock
);
    // Phase counters, one per source
    int xc = 0;
    int ic = 0;
    int wc = 0;
    int dc = 0;

    initial begin
        direct_clock_input = 1'b0;
        crystal_input = 1'b0;
        internal_osc_input = 1'b0;
        wakeup_oscillator_clock = 1'b0;
    end

    // Oscillators run whether or not the generator listens
    always @(posedge sys_clk) begin
        xc <= (xc + 1 >= XTAL_HALF) ? 0 : xc + 1;
        if (xc + 1 >= XTAL_HALF) crystal_input <= ~crystal_input;
        ic <= (ic + 1 >= INT_HALF) ? 0 : ic + 1;
        if (ic + 1 >= INT_HALF) internal_osc_input <= ~internal_osc_input;
        wc <= (wc + 1 >= WU_HALF) ? 0 : wc + 1;
        if (wc + 1 >= WU_HALF) begin
            wakeup_oscillator_clock <= ~wakeup_oscillator_clock;
        end
        // Uneven duty so a pass-through can be told from a divider
        if (dc + 1 >= (direct_clock_input ? DIR_HI : DIR_LO)) begin
            dc <= 0;
            direct_clock_input <= ~direct_clock_input;
        end else begin
            dc <= dc + 1;
        end
    end
endmodule : scg_src_model

// ---- verif/scg_core_tb.sv ----
// Self-checking bench for the system clock generator.
// Assumes scg_src_model supplies the four source clocks.
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_core_tb
    import scg_pkg::*;
;
    typedef struct {
        logic [31:0] exp;
        logic [31:0] mask;
    } scg_rd_note_type;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    scg_bus_type bus = '0;
    logic [31:0] rd_data;
    logic direct_clock_input, crystal_input;
    logic internal_osc_input, wakeup_oscillator_clock;
    logic system_clock, pll_locked, switch_busy;
    int failures = 0;
    int check_count = 0;
    int seed = 34;
    int k, lo, hi, per_len, ph_len;
    scg_rd_note_type note;
    scg_rd_note_type rd_q[$];
    int per_lo[$];
    int per_hi[$];
    logic per_arm = 1'b0;
    logic rd_pend = 1'b0;
    logic ph_started = 1'b0;
    logic prev_clk = 1'b0;

    scg_core scg_core_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .bus(bus), .rd_data(rd_data),
        .direct_clock_input(direct_clock_input),
        .crystal_input(crystal_input),
        .internal_osc_input(internal_osc_input),
        .wakeup_oscillator_clock(wakeup_oscillator_clock),
        .system_clock(system_clock), .pll_locked(pll_locked),
        .switch_busy(switch_busy));

    scg_src_model scg_src_model_inst (.sys_clk(sys_clk),
        .direct_clock_input(direct_clock_input),
        .crystal_input(crystal_input),
        .internal_osc_input(internal_osc_input),
        .wakeup_oscillator_clock(wakeup_oscillator_clock));

    // 25 MHz system clock
    always #20 sys_clk = ~sys_clk;

    // Compare one value and count it
    task check(input string what, input logic [31:0] e,
               input logic [31:0] s);
        check_count++;
        if (e !== s) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : check

    // Print the counts and the verdict, then end the run
    task stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // One-cycle register write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr

    // One-cycle register read, expectation noted for the monitor
    task rd(input logic [7:0] a, input logic [31:0] e,
            input logic [31:0] m);
        scg_rd_note_type n;
        n.exp = e;
        n.mask = m;
        rd_q.push_back(n);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
    endtask : rd

    // Wait for a source switch to finish, bounded
    task settle;
        int n;
        n = 0;
        repeat (3) @(posedge sys_clk);
        while (switch_busy !== 1'b0 && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        check("switch_busy", 1'b0, switch_busy);
    endtask : settle

    // Note expected output periods and let the monitor measure them
    task period(input int l, input int h, input int skip, input int reps);
        int n;
        n = 0;
        repeat (skip) @(posedge sys_clk);
        repeat (reps) begin
            per_lo.push_back(l);
            per_hi.push_back(h);
        end
        per_arm <= 1'b1;
        while (per_lo.size() > 0 && n < 40000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 40000) check("period_wait", 1'b0, 1'b1);
        per_arm <= 1'b0;
    endtask : period

    // Direct mode: output is the input one cycle late, duty kept
    task direct_track;
        logic p;
        @(posedge sys_clk);
        p = direct_clock_input;
        repeat (40) begin
            @(posedge sys_clk);
            check("direct", p, system_clock);
            p = direct_clock_input;
        end
    endtask : direct_track

    // Monitor: read data, output periods and phase lengths
    always @(posedge sys_clk) begin
        if (rd_pend) begin
            note = rd_q.pop_front();
            check("rd_data", note.exp, rd_data & note.mask);
        end
        rd_pend <= bus.rd;
        per_len = per_len + 1;
        ph_len = ph_len + 1;
        if (system_clock !== prev_clk) begin
            // No phase shorter than the shortest source phase
            if (ph_started && reset_n && ph_len < 3) begin
                check("phase_short", 1'b0, 1'b1);
            end
            ph_started = reset_n;
            ph_len = 0;
            if (system_clock === 1'b1) begin
                if (per_arm && per_lo.size() > 0) begin
                    lo = per_lo.pop_front();
                    hi = per_hi.pop_front();
                    check("period", 1'b1, per_len >= lo && per_len <= hi);
                end
                per_len = 0;
            end
        end
        prev_clk = system_clock;
    end

    // Hang guard, well beyond the planned run
    initial begin
        #(40 * 95000);
        check("watchdog", 1'b0, 1'b1);
        stop_test();
    end

    // Main sequence
    initial begin
        int n;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`SCG_CTRL_OFS, 32'h04, 32'hffffffff);
        rd(`SCG_PRESC_OFS, 32'h0, 32'hffffffff);
        rd(`SCG_PLLDIV_OFS, 32'h0, 32'hffffffff);
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h0, 32'hffffffff);
        period(12, 12, 30, 3);
        wr(`SCG_CTRL_OFS, 32'h3);
        settle();
        direct_track();
        period(8, 8, 0, 3);
        rd(`SCG_STATUS_OFS, 32'h03, 32'h1f);
        wr(`SCG_STATUS_OFS, 32'hffffffff);
        rd(`SCG_CTRL_OFS, 32'h03, 32'hffffffff);
        // Divider is written before the source is switched
        wr(`SCG_PRESC_OFS, 32'h0);
        wr(`SCG_CTRL_OFS, 32'h6);
        settle();
        period(32, 32, 70, 2);
        k = 1 + ($unsigned($random(seed)) % 3);
        wr(`SCG_PRESC_OFS, k);
        period(32 * (k + 1), 32 * (k + 1), 64 * (k + 2), 2);
        // Reserved band code is ignored, valid one kept
        wr(`SCG_CTRL_OFS, 32'h26);
        rd(`SCG_CTRL_OFS, 32'h06, 32'hffffffff);
        wr(`SCG_CTRL_OFS, 32'h16);
        rd(`SCG_CTRL_OFS, 32'h16, 32'hffffffff);
        wr(`SCG_CTRL_OFS, 32'h06);
        wr(`SCG_PRESC_OFS, 32'h2);
        wr(`SCG_CTRL_OFS, 32'h0e);
        settle();
        period(18, 18, 60, 2);
        wr(`SCG_PRESC_OFS, 32'h3ff);
        period(6144, 6144, 6200, 1);
        // PLL: P=2, N=4, K2=2 on a 32-cycle reference
        wr(`SCG_PRESC_OFS, 32'h0);
        wr(`SCG_PLLDIV_OFS, 32'h00010301);
        wr(`SCG_CTRL_OFS, 32'h02);
        settle();
        n = 0;
        while (pll_locked !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        check("pll_locked", 1'b1, pll_locked);
        period(28, 36, 200, 4);
        // One frequency step only: K2 to one doubles the output
        wr(`SCG_PLLDIV_OFS, 32'h00000301);
        period(14, 18, 300, 4);
        wr(`SCG_CTRL_OFS, 32'h0);
        settle();
        period(12, 12, 30, 2);
        stop_test();
    end
endmodule : scg_core_tb
